// >>> src/trs_reset_scope.v
// Reset and power-down scope for a multi-channel transceiver block.
// Assumes all control inputs come from fabric logic on another clock.
//
// How it works
// - PLL reset clears only the transmit PLLs.
// - Transmit digital reset clears transmit PCS, not buffer.
// - Receive digital reset clears all receive PCS blocks.
// - Receive analog reset clears only clock recovery.
// - Power-down clears all channel blocks, not PLLs.
// - XAUI channels are always bonded.
// - Bonded XAUI groups four channels, one sequence.
// - Busy low first cycle, high from second.
// - Lock inputs select reference, data or automatic mode.
// - Automatic and manual lock in all non-PCIe modes; pcie_mode is unused, so PCIe mode gets them too.
// - Frequency lock high in data mode only.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.vh"

module trs_reset_scope #(
    parameter CHANNELS = 4,
    parameter CANCEL_CYCLES = `TRS_OFFSET_CANCEL_CYCLES
) (
    input wire clk,
    input wire reset,
    input wire pll_reset,
    input wire pll_lock_in,
    input wire block_power_down,
    input wire xaui_mode,
    input wire pcie_mode,
    input wire [CHANNELS-1:0] tx_digital_reset,
    input wire [CHANNELS-1:0] rx_digital_reset,
    input wire [CHANNELS-1:0] rx_analog_reset,
    input wire [CHANNELS-1:0] reference_lock_mode,
    input wire [CHANNELS-1:0] data_lock_mode,
    output reg pll_clear_r,
    output reg pll_locked_r,
    output reg [CHANNELS*`TRS_TX_W-1:0] tx_clear_r,
    output reg [CHANNELS*`TRS_RX_W-1:0] rx_clear_r,
    output wire [CHANNELS*`TRS_MODE_W-1:0] lock_mode,
    output wire [CHANNELS-1:0] freq_locked,
    output reg busy_r,
    output reg bond_error_r
);

    localparam NSYNC = 5 + 5 * CHANNELS;
    // Resets and power-down start asserted so no clear drops while the synchronisers fill.
    localparam [NSYNC-1:0] SYNC_INIT = {{2*CHANNELS{1'b0}}, {3*CHANNELS{1'b1}}, 5'h05};
    localparam CW = 16;

    localparam ST_START = 2'h0;
    localparam ST_CANCEL = 2'h1;
    localparam ST_IDLE = 2'h2;

    // Three-stage synchronisers; stage 1 feeds only stage 2.
    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] s1_r;
    reg [NSYNC-1:0] s2_r;
    reg [NSYNC-1:0] s3_r;
    reg [NSYNC-1:0] clean_r;

    assign raw_in = {data_lock_mode, reference_lock_mode, rx_analog_reset,
                     rx_digital_reset, tx_digital_reset, pcie_mode, xaui_mode,
                     block_power_down, pll_lock_in, pll_reset};

    always @(posedge clk) begin
        if (reset) begin
            s1_r <= SYNC_INIT;
            s2_r <= SYNC_INIT;
            s3_r <= SYNC_INIT;
            clean_r <= SYNC_INIT;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A change counts once stages two and three agree.
            clean_r <= (s2_r & s3_r) | (clean_r & (s2_r | s3_r));
        end
    end

    wire c_pll_reset = clean_r[0];
    wire c_pll_lock = clean_r[1];
    wire c_pd = clean_r[2];
    wire c_xaui = clean_r[3];
    wire [CHANNELS-1:0] c_txd = clean_r[5 +: CHANNELS];
    wire [CHANNELS-1:0] c_rxd = clean_r[5+CHANNELS +: CHANNELS];
    wire [CHANNELS-1:0] c_rxa = clean_r[5+2*CHANNELS +: CHANNELS];
    wire [CHANNELS-1:0] c_ref = clean_r[5+3*CHANNELS +: CHANNELS];
    wire [CHANNELS-1:0] c_dat = clean_r[5+4*CHANNELS +: CHANNELS];

    // Returns the OR of the bits of a four-channel group.
    function group_any;
        input [CHANNELS-1:0] v;
        input integer g;
        integer k;
        begin
            group_any = 1'b0;
            for (k = 0; k < `TRS_XAUI_GROUP; k = k + 1) begin
                if (g * `TRS_XAUI_GROUP + k < CHANNELS) begin
                    group_any = group_any | v[g * `TRS_XAUI_GROUP + k];
                end
            end
        end
    endfunction

    // In XAUI mode each channel takes its group's reset, so a group resets as one.
    reg [CHANNELS-1:0] eff_txd;
    reg [CHANNELS-1:0] eff_rxd;
    reg [CHANNELS-1:0] eff_rxa;
    integer i;

    always @* begin
        for (i = 0; i < CHANNELS; i = i + 1) begin
            if (c_xaui) begin
                eff_txd[i] = group_any(c_txd, i / `TRS_XAUI_GROUP);
                eff_rxd[i] = group_any(c_rxd, i / `TRS_XAUI_GROUP);
                eff_rxa[i] = group_any(c_rxa, i / `TRS_XAUI_GROUP);
            end else begin
                eff_txd[i] = c_txd[i];
                eff_rxd[i] = c_rxd[i];
                eff_rxa[i] = c_rxa[i];
            end
        end
    end

    // Sub-block clears per channel.
    integer c;
    always @(posedge clk) begin
        if (reset) begin
            pll_clear_r <= 1'b1;
            pll_locked_r <= 1'b0;
            tx_clear_r <= {CHANNELS*`TRS_TX_W{1'b1}};
            rx_clear_r <= {CHANNELS*`TRS_RX_W{1'b1}};
        end else begin
            pll_clear_r <= c_pll_reset;
            pll_locked_r <= c_pll_lock && !c_pll_reset;
            for (c = 0; c < CHANNELS; c = c + 1) begin
                tx_clear_r[c*`TRS_TX_W + `TRS_TX_PCFIFO] <= eff_txd[c] | c_pd;
                tx_clear_r[c*`TRS_TX_W + `TRS_TX_BYTESER] <= eff_txd[c] | c_pd;
                tx_clear_r[c*`TRS_TX_W + `TRS_TX_ENC] <= eff_txd[c] | c_pd;
                tx_clear_r[c*`TRS_TX_W + `TRS_TX_SER] <= eff_txd[c] | c_pd;
                tx_clear_r[c*`TRS_TX_W + `TRS_TX_XAUI] <= eff_txd[c] | c_pd;
                tx_clear_r[c*`TRS_TX_W + `TRS_TX_BUF] <= c_pd;
                rx_clear_r[c*`TRS_RX_W + `TRS_RX_BUF] <= c_pd;
                rx_clear_r[c*`TRS_RX_W + `TRS_RX_DESER] <= c_pd;
                rx_clear_r[c*`TRS_RX_W + `TRS_RX_CDR] <= eff_rxa[c] | c_pd;
                rx_clear_r[c*`TRS_RX_W + `TRS_RX_ALIGN +: 9] <= {9{eff_rxd[c] | c_pd}};
            end
        end
    end

    // Lock-mode decode per channel.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : ch
            wire [`TRS_MODE_W-1:0] m;
            wire fl;
            trs_lock_mode u_mode (
                .clk(clk),
                .reset(reset),
                .reference_lock_mode(c_ref[g]),
                .data_lock_mode(c_dat[g]),
                .cdr_clear(rx_clear_r[g*`TRS_RX_W + `TRS_RX_CDR]),
                .mode_r(m),
                .freq_locked_r(fl)
            );
            assign lock_mode[g*`TRS_MODE_W +: `TRS_MODE_W] = m;
            assign freq_locked[g] = fl;
        end
    endgenerate

    // Busy: low for one cycle after reset, then high during offset cancellation.
    reg [1:0] st_r;
    reg [CW-1:0] cnt_r;
    always @(posedge clk) begin
        if (reset) begin
            st_r <= ST_START;
            cnt_r <= {CW{1'b0}};
            busy_r <= 1'b0;
        end else begin
            case (st_r)
                ST_START: begin
                    busy_r <= 1'b1;
                    cnt_r <= CANCEL_CYCLES[CW-1:0];
                    st_r <= ST_CANCEL;
                end
                ST_CANCEL: begin
                    if (cnt_r <= 16'h0001) begin
                        busy_r <= 1'b0;
                        st_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                ST_IDLE: begin
                    busy_r <= 1'b0;
                end
                default: begin
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // XAUI needs whole four-channel groups.
    always @(posedge clk) begin
        if (reset) begin
            bond_error_r <= 1'b0;
        end else begin
            bond_error_r <= c_xaui && ((CHANNELS % `TRS_XAUI_GROUP) != 0);
        end
    end

endmodule // trs_reset_scope
`default_nettype wire

// >>> src/trs_consts.vh
// Constants for the transceiver reset scope controller.
// Assumes inclusion by bare name from files under src/.
`ifndef TRS_CONSTS_VH
`define TRS_CONSTS_VH

// Lock mode codes of the clock recovery.
`define TRS_MODE_W 2
`define TRS_MODE_AUTO 2'h0
`define TRS_MODE_MAN_REF 2'h1
`define TRS_MODE_MAN_DATA 2'h2

// Transmit sub-block clear vector bit positions.
`define TRS_TX_PCFIFO 0
`define TRS_TX_BYTESER 1
`define TRS_TX_ENC 2
`define TRS_TX_SER 3
`define TRS_TX_XAUI 4
`define TRS_TX_BUF 5
`define TRS_TX_W 6

// Receive sub-block clear vector bit positions.
`define TRS_RX_BUF 0
`define TRS_RX_CDR 1
`define TRS_RX_DESER 2
`define TRS_RX_ALIGN 3
`define TRS_RX_DESKEW 4
`define TRS_RX_RATECOMP 5
`define TRS_RX_DEC 6
`define TRS_RX_BYTEDES 7
`define TRS_RX_ORDER 8
`define TRS_RX_PCFIFO 9
`define TRS_RX_XAUI 10
`define TRS_RX_BIST 11
`define TRS_RX_W 12

// Busy output: cycles low after power-up before it is raised.
`define TRS_BUSY_LOW_CYCLES 1
// Offset cancellation length in reconfiguration clock cycles.
`define TRS_OFFSET_CANCEL_CYCLES 64

// Bonded XAUI group size.
`define TRS_XAUI_GROUP 4

`endif

// >>> src/trs_lock_mode.v
// Lock mode decoder and frequency-lock status for one channel.
// Assumes lock inputs are already in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.vh"

module trs_lock_mode (
    input wire clk,
    input wire reset,
    input wire reference_lock_mode,
    input wire data_lock_mode,
    input wire cdr_clear,
    output reg [`TRS_MODE_W-1:0] mode_r,
    output reg freq_locked_r
);

    reg [`TRS_MODE_W-1:0] mode_nxt;

    always @* begin
        if (data_lock_mode) begin
            mode_nxt = `TRS_MODE_MAN_DATA;
        end else if (reference_lock_mode) begin
            mode_nxt = `TRS_MODE_MAN_REF;
        end else begin
            mode_nxt = `TRS_MODE_AUTO;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            mode_r <= `TRS_MODE_AUTO;
            freq_locked_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            // Data lock only once the clock recovery is out of its own reset.
            freq_locked_r <= (mode_nxt == `TRS_MODE_MAN_DATA) && !cdr_clear;
        end
    end

endmodule // trs_lock_mode
`default_nettype wire

// >>> verif/trs_reset_scope_assertions.sv
// Checker for the reset scope block, channel 0 view.
// Assumes bind from tb; XAUI groups are four channels.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.vh"
module trs_reset_scope_assertions #(
    parameter CHANNELS = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pll_reset,
    input wire logic block_power_down,
    input wire logic xaui_mode,
    input wire logic [CHANNELS-1:0] tx_digital_reset,
    input wire logic [CHANNELS-1:0] rx_digital_reset,
    input wire logic [CHANNELS-1:0] rx_analog_reset,
    input wire logic [CHANNELS-1:0] reference_lock_mode,
    input wire logic [CHANNELS-1:0] data_lock_mode,
    input wire logic pll_clear_r,
    input wire logic [CHANNELS*`TRS_TX_W-1:0] tx_clear_r,
    input wire logic [CHANNELS*`TRS_RX_W-1:0] rx_clear_r,
    input wire logic [CHANNELS*`TRS_MODE_W-1:0] lock_mode,
    input wire logic [CHANNELS-1:0] freq_locked,
    input wire logic busy_r
);
    wire pd = block_power_down;
    wire [5*CHANNELS+2:0] ins = {pll_reset, pd, xaui_mode, tx_digital_reset,
        rx_digital_reset, rx_analog_reset, reference_lock_mode, data_lock_mode};
    wire t0 = (xaui_mode ? |tx_digital_reset[3:0] : tx_digital_reset[0]) | pd;
    wire d0 = (xaui_mode ? |rx_digital_reset[3:0] : rx_digital_reset[0]) | pd;
    wire a0 = (xaui_mode ? |rx_analog_reset[3:0] : rx_analog_reset[0]) | pd;
    wire [1:0] m0 = data_lock_mode[0] ? `TRS_MODE_MAN_DATA :
        (reference_lock_mode[0] ? `TRS_MODE_MAN_REF : `TRS_MODE_AUTO);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence calm;
        $stable(ins)[*7];
    endsequence
    pll_scope_a: assert property (calm |-> pll_clear_r == pll_reset)
        else $error("pll clear wrong");
    tx_scope_a: assert property (calm |-> tx_clear_r[4:0] == {5{t0}})
        else $error("tx clear wrong");
    tx_buffer_a: assert property (calm |-> tx_clear_r[5] == pd)
        else $error("tx buffer clear wrong");
    rx_digital_a: assert property (calm |-> rx_clear_r[11:3] == {9{d0}})
        else $error("rx digital clear wrong");
    rx_analog_a: assert property (calm |-> rx_clear_r[1] == a0)
        else $error("cdr clear wrong");
    rx_power_a: assert property (calm |-> {rx_clear_r[2], rx_clear_r[0]} == {2{pd}})
        else $error("rx buffer clear wrong");
    busy_start_a: assert property ($fell(reset) |-> !busy_r ##1 busy_r[*3] ##[1:3] !busy_r)
        else $error("busy start wrong");
    lock_select_a: assert property (calm |-> lock_mode[1:0] == m0)
        else $error("lock mode wrong");
    freq_lock_a: assert property (calm |->
        freq_locked[0] == (m0 == `TRS_MODE_MAN_DATA && !a0))
        else $error("freq lock wrong");
    cover property (calm ##0 freq_locked[0]);
    cover property ($fell(busy_r));
    cover property (calm ##0 pd);
endmodule // trs_reset_scope_assertions
`default_nettype wire

// >>> verif/trs_ctrl_model.sv
// Behavioural fabric reset controller, one bonded group of four.
// Assumes inputs come from the reset scope block.
`timescale 1ns/1ps
`default_nettype none
module trs_ctrl_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic busy,
    input wire logic pll_locked,
    input wire logic [3:0] freq_locked,
    output logic pll_rst,
    output logic tx_rst,
    output logic rx_ana_rst,
    output logic rx_dig_rst,
    output logic to_data
);
    // One non-PCIe sequence drives the whole group.
    initial begin
        pll_rst = 1'b1;
        tx_rst = 1'b1;
        rx_ana_rst = 1'b1;
        rx_dig_rst = 1'b1;
        to_data = 1'b0;
        @(negedge reset);
        repeat (40) @(negedge clk);
        pll_rst = 1'b0;
        wait (pll_locked);
        @(negedge clk);
        tx_rst = 1'b0;
        while (busy !== 1'b0) @(negedge clk);
        repeat (2) @(negedge clk);
        rx_ana_rst = 1'b0;
        to_data = 1'b1;
        while (freq_locked !== 4'hf) @(negedge clk);
        rx_dig_rst = 1'b0;
    end
endmodule // trs_ctrl_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the reset scope block, four channels.
// Assumes design under src/ and a short offset cancel count.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.vh"
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic man = 1'b0;
    logic pll_lock_in = 1'b0;
    logic xaui_mode = 1'b0;
    logic [4:0] mv = 5'h0;
    logic [3:0] msk = 4'h1;
    logic [1:0] lk = 2'h0;
    int num_errors = 0;
    int total_checks = 0;
    wire p_pll, p_tx, p_ra, p_rd, p_dl, pll_clear_r, busy_r, pll_locked_r, bond_err;
    wire [23:0] tx_clear_r;
    wire [47:0] rx_clear_r;
    wire [7:0] lock_mode;
    wire [3:0] freq_locked;
    wire pll_reset = man ? mv[4] : p_pll;
    wire pd = man & mv[0];
    wire [3:0] tx_rst = man ? {4{mv[3]}} & msk : {4{p_tx}};
    wire [3:0] rd_rst = man ? {4{mv[2]}} & msk : {4{p_rd}};
    wire [3:0] ra_rst = man ? {4{mv[1]}} & msk : {4{p_ra}};
    wire [3:0] ref_l = man ? {3'h0, lk[0]} : {4{!p_dl}};
    wire [3:0] dat_l = man ? {3'h0, lk[1]} : {4{p_dl}};
    trs_reset_scope #(.CHANNELS(4), .CANCEL_CYCLES(4)) u_dut (.clk(clk), .reset(reset),
        .pll_reset(pll_reset), .pll_lock_in(pll_lock_in), .block_power_down(pd),
        .xaui_mode(xaui_mode), .pcie_mode(1'b0), .tx_digital_reset(tx_rst),
        .rx_digital_reset(rd_rst), .rx_analog_reset(ra_rst), .reference_lock_mode(ref_l),
        .data_lock_mode(dat_l), .pll_clear_r(pll_clear_r), .pll_locked_r(pll_locked_r),
        .tx_clear_r(tx_clear_r), .rx_clear_r(rx_clear_r), .lock_mode(lock_mode),
        .freq_locked(freq_locked), .busy_r(busy_r), .bond_error_r(bond_err));
    trs_ctrl_model u_ctrl (.clk(clk), .reset(reset), .busy(busy_r), .pll_locked(pll_locked_r),
        .freq_locked(freq_locked), .pll_rst(p_pll), .tx_rst(p_tx), .rx_ana_rst(p_ra),
        .rx_dig_rst(p_rd), .to_data(p_dl));
    initial forever #12.5 clk = ~clk;
    always @(negedge clk) pll_lock_in <= !pll_reset;
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [4:0] v, input logic [3:0] m);
        @(negedge clk);
        mv = v;
        msk = m;
        repeat (8) @(negedge clk);
    endtask
    // Order: pll, tx buffer, tx pcs, rx pcs, deserializer, cdr, rx buffer.
    function automatic logic [18:0] scope(input logic [4:0] v);
        return {v[4], v[0], {5{v[3] | v[0]}}, {9{v[2] | v[0]}}, v[0], v[1] | v[0], v[0]};
    endfunction
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        logic [18:0] e;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 400 && rx_clear_r[3] !== 1'b0; i++) @(negedge clk);
        chk({pll_clear_r, busy_r, tx_clear_r, rx_clear_r, freq_locked}, 4'hf);
        man = 1'b1;
        for (int i = 0; i < 6; i++) begin
            put(5'h1 << i, 4'h1);
            chk({pll_clear_r, tx_clear_r[5:0], rx_clear_r[11:0]}, scope(mv));
            e = scope(mv & 5'h1);
            chk({tx_clear_r[11:6], rx_clear_r[23:12]}, e[17:0]);
            chk(pll_locked_r, !mv[4]);
        end
        xaui_mode = 1'b1;
        put(5'h04, 4'h4);
        chk(rx_clear_r[11:3], 9'h1ff);
        chk(bond_err, 1'b0);
        xaui_mode = 1'b0;
        for (int i = 0; i < 4; i++) begin
            lk = i[1:0];
            put(5'h0, 4'h1);
            chk({lock_mode[1:0], freq_locked[0]}, {i[1] ? `TRS_MODE_MAN_DATA : (i[0] ?
                `TRS_MODE_MAN_REF : `TRS_MODE_AUTO), i[1]});
        end
        put(5'h02, 4'h1);
        chk(freq_locked[0], 1'b0);
        give_verdict;
    end
    initial begin
        #(25 * 4000);
        num_errors++;
        give_verdict;
    end
endmodule // tb
bind trs_reset_scope trs_reset_scope_assertions #(.CHANNELS(CHANNELS)) u_chk (.clk(clk),
    .reset(reset), .pll_reset(pll_reset), .block_power_down(block_power_down),
    .xaui_mode(xaui_mode), .tx_digital_reset(tx_digital_reset),
    .rx_digital_reset(rx_digital_reset), .rx_analog_reset(rx_analog_reset),
    .reference_lock_mode(reference_lock_mode), .data_lock_mode(data_lock_mode),
    .pll_clear_r(pll_clear_r), .tx_clear_r(tx_clear_r), .rx_clear_r(rx_clear_r),
    .lock_mode(lock_mode), .freq_locked(freq_locked), .busy_r(busy_r));
`default_nettype wire
